// [rtl/tpm_pkg.sv]
// Purpose: constants for the transceiver power-mode state machine
// Assumes: 40 MHz system clock
// Notes:   mode codes are the three-bit mode select field encodings
package tpm_pkg;
  typedef enum logic [2:0] {TPM_OFF, TPM_STARTUP, TPM_STANDBY, TPM_NORMAL, TPM_SLEEP,
                            TPM_OVERTEMP} tpm_state_e;
  localparam logic [2:0]  MODE_SLEEP      = 3'h1;
  localparam logic [2:0]  MODE_STANDBY    = 3'h4;
  localparam logic [2:0]  MODE_NORMAL     = 3'h7;
  localparam int          CLK_PERIOD_NS   = 25;
  localparam int          STARTUP_TIME_US = 100;
  localparam int          STARTUP_CYCLES  = (STARTUP_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
  localparam int          UV_DET_TIME_US  = 10;
  localparam int          UV_DET_CYCLES   = (UV_DET_TIME_US * 1000 + CLK_PERIOD_NS - 1)
                                            / CLK_PERIOD_NS;
  localparam int          CNT_W           = 16;
  localparam logic        WAKE_EN_RESET   = 1'b1;
endpackage

// [rtl/tpm_mode_fsm.sv]
// Overview of operation
// - one mode machine: Normal, Standby, Sleep, Overtemp, Off
// - mode code 111 from Standby or Sleep enters Normal
// - Standby: no bus traffic, regulator inhibit output stays active
// - Standby with bus wake enabled watches bus for wake-up
// - selective wake only when enable and config valid both set
// - receive pin low while enabled wake or interrupt event pending
// - enabled wake or interrupt event moves Sleep to Standby
// - spi fault never wakes; mode command wakes only with io supply
// - mode code 100 from Normal or Sleep enters Standby
// - 001 enters Sleep only if nothing pending and a wake source enabled
// - Sleep as Standby but regulator inhibit output released
// - long supply undervoltage forces Sleep
// - forced Sleep clears pending wakes, sets wake enables, clears selective
// - sleep cause flag 0 for command, 1 for undervoltage
// - Off at first power; any state to Off on battery loss
// - Off floats bus outputs and regulator inhibit output
// - battery power-on runs startup delay then enters Standby
// - Normal to Overtemp at once above protection threshold
// - warning sets status; event only when irq enable set
// - Overtemp floats bus, ignores wakes, pending wake holds receive low
// - Overtemp leaves to Standby on cool-down or Off on battery loss
// - mode field codes 001 Sleep, 100 Standby, 111 Normal
// - normal-mode pending flag 1 after power-up until first Normal
//
// Purpose: operating-mode controller of a partial-networking transceiver
// Assumes: mode commands arrive as pulses in the link clock domain
// Notes:   battery power-on arrives on bat_pon_i and starts Off to startup; rst_i loads Off
`timescale 1ns/10ps
module tpm_mode_fsm
  import tpm_pkg::*;
#(
  parameter int STARTUP_CNT = STARTUP_CYCLES,
  parameter int UV_CNT      = UV_DET_CYCLES
)(
  input  wire logic       clock_i,
  input  wire logic       rst_i,
  input  wire logic       link_clk_i,
  input  wire logic       link_rst_i,
  input  wire logic       mode_wr_i,
  input  wire logic [2:0] mode_select_field_i,
  input  wire logic       bat_pon_i,
  input  wire logic       bat_poff_i,
  input  wire logic       vcc_uv_i,
  input  wire logic       io_supply_uv_i,
  input  wire logic       io_supply_ok_i,
  input  wire logic       otp_act_i,
  input  wire logic       otp_rel_i,
  input  wire logic       otw_i,
  input  wire logic       overtemp_warning_irq_enable_i,
  input  wire logic       wake_event_i,
  input  wire logic       irq_event_i,
  input  wire logic       spi_fault_event_i,
  input  wire logic       bus_wake_enable_set_i,
  input  wire logic       bus_wake_enable_clr_i,
  input  wire logic       local_wake_en_set_i,
  input  wire logic       local_wake_en_clr_i,
  input  wire logic       selective_wake_enable_set_i,
  input  wire logic       selective_wake_enable_clr_i,
  input  wire logic       selective_wake_config_valid_i,
  input  wire logic       wake_clear_i,
  output tpm_state_e      state_o,
  output logic            regulator_inhibit_output_o,
  output logic            regulator_inhibit_output_oe_o,
  output logic            bus_out_en_o,
  output logic            trx_active_o,
  output logic            bus_monitor_o,
  output logic            selective_wake_mode_o,
  output logic            rxd_low_o,
  output logic            bus_wake_enable_o,
  output logic            local_wake_falling_enable_o,
  output logic            local_wake_rising_enable_o,
  output logic            selective_wake_enable_o,
  output logic            sleep_cause_flag_o,
  output logic            overtemp_warning_status_o,
  output logic            overtemp_warning_event_o,
  output logic            normal_mode_pending_flag_o
);

  // ****************************************
  // link-domain command capture
  // ****************************************
  logic       cmd_tgl_reg;
  logic [2:0] cmd_code_reg;

  always_ff @(posedge link_clk_i)
  begin
    if (link_rst_i)
    begin
      cmd_tgl_reg  <= 1'b0;
      cmd_code_reg <= 3'h0;
    end
    else if (mode_wr_i)
    begin
      cmd_tgl_reg  <= ~cmd_tgl_reg;
      cmd_code_reg <= mode_select_field_i;
    end
  end

  // ****************************************
  // synchronisers
  // ****************************************
  localparam int NSYNC = 10;
  logic [NSYNC-1:0] async_in;
  logic [NSYNC-1:0] sync1_reg;
  logic [NSYNC-1:0] sync2_reg;
  logic             tgl_seen_reg;

  assign async_in = {cmd_tgl_reg, bat_pon_i, bat_poff_i, vcc_uv_i, io_supply_uv_i,
                     io_supply_ok_i, otp_act_i, otp_rel_i, otw_i, wake_event_i};

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      sync1_reg    <= '0;
      sync2_reg    <= '0;
      tgl_seen_reg <= 1'b0;
    end
    else
    begin
      sync1_reg    <= async_in;
      sync2_reg    <= sync1_reg;
      tgl_seen_reg <= sync2_reg[9];
    end
  end

  logic cmd_valid;
  logic s_pon;
  logic s_poff;
  logic s_vcc_uv;
  logic s_io_uv;
  logic s_io_ok;
  logic s_otp_act;
  logic s_otp_rel;
  logic s_otw;
  logic s_wake;
  // code is stable for the toggle's two-cycle latency, so sampling it then is safe
  assign cmd_valid = sync2_reg[9] ^ tgl_seen_reg;
  assign s_pon     = sync2_reg[8];
  assign s_poff    = sync2_reg[7];
  assign s_vcc_uv  = sync2_reg[6];
  assign s_io_uv   = sync2_reg[5];
  assign s_io_ok   = sync2_reg[4];
  assign s_otp_act = sync2_reg[3];
  assign s_otp_rel = sync2_reg[2];
  assign s_otw     = sync2_reg[1];
  assign s_wake    = sync2_reg[0];

  // ****************************************
  // undervoltage timer and startup timer
  // ****************************************
  logic [CNT_W-1:0] uv_cnt_reg;
  logic [CNT_W-1:0] start_cnt_reg;
  logic             uv_force;

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      uv_cnt_reg <= '0;
    else if (!(s_vcc_uv || s_io_uv))
      uv_cnt_reg <= '0;
    else if (uv_cnt_reg != CNT_W'(UV_CNT))
      uv_cnt_reg <= uv_cnt_reg + 1'b1;
  end
  assign uv_force = (uv_cnt_reg == CNT_W'(UV_CNT));

  tpm_state_e state_reg;
  tpm_state_e state_next;

  always_ff @(posedge clock_i)
  begin
    if (rst_i || state_reg != TPM_STARTUP)
      start_cnt_reg <= '0;
    else if (start_cnt_reg != CNT_W'(STARTUP_CNT))
      start_cnt_reg <= start_cnt_reg + 1'b1;
  end

  // ****************************************
  // wake events and enables
  // ****************************************
  logic pending_reg;
  logic wake_hit;
  logic any_src_en;
  logic uv_sleep;

  assign any_src_en = bus_wake_enable_o || local_wake_falling_enable_o
                      || local_wake_rising_enable_o;
  // no new wakes detected in Overtemp or Off
  assign wake_hit   = (s_wake || irq_event_i || spi_fault_event_i)
                      && state_reg != TPM_OVERTEMP && state_reg != TPM_OFF
                      && state_reg != TPM_STARTUP;
  assign uv_sleep   = uv_force && state_reg != TPM_SLEEP && state_reg != TPM_OFF
                      && state_reg != TPM_STARTUP && state_reg != TPM_OVERTEMP;

  // forced sleep clears pending; set wins over software clear
  always_ff @(posedge clock_i)
  begin
    if (rst_i || uv_sleep)
      pending_reg <= 1'b0;
    else if (wake_hit)
      pending_reg <= 1'b1;
    else if (wake_clear_i)
      pending_reg <= 1'b0;
  end

  // forced wake enables on undervoltage sleep
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      bus_wake_enable_o           <= WAKE_EN_RESET;
      local_wake_falling_enable_o <= WAKE_EN_RESET;
      local_wake_rising_enable_o  <= WAKE_EN_RESET;
      selective_wake_enable_o     <= 1'b0;
    end
    else if (uv_sleep)
    begin
      bus_wake_enable_o           <= 1'b1;
      local_wake_falling_enable_o <= 1'b1;
      local_wake_rising_enable_o  <= 1'b1;
      selective_wake_enable_o     <= 1'b0;
    end
    else
    begin
      if (bus_wake_enable_set_i)
        bus_wake_enable_o <= 1'b1;
      else if (bus_wake_enable_clr_i)
        bus_wake_enable_o <= 1'b0;
      if (local_wake_en_set_i)
      begin
        local_wake_falling_enable_o <= 1'b1;
        local_wake_rising_enable_o  <= 1'b1;
      end
      else if (local_wake_en_clr_i)
      begin
        local_wake_falling_enable_o <= 1'b0;
        local_wake_rising_enable_o  <= 1'b0;
      end
      if (selective_wake_enable_set_i)
        selective_wake_enable_o <= 1'b1;
      else if (selective_wake_enable_clr_i)
        selective_wake_enable_o <= 1'b0;
    end
  end

  // ****************************************
  // mode state machine
  // ****************************************
  // five-mode machine plus boot hold
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      TPM_OFF:
        if (s_pon && !s_poff)
          state_next = TPM_STARTUP;
      TPM_STARTUP:
        if (start_cnt_reg == CNT_W'(STARTUP_CNT))
          state_next = TPM_STANDBY;
      TPM_STANDBY:
        if (cmd_valid && cmd_code_reg == MODE_NORMAL)
          state_next = TPM_NORMAL;
        // sleep guarded by pending and sources
        else if (cmd_valid && cmd_code_reg == MODE_SLEEP && !pending_reg && any_src_en)
          state_next = TPM_SLEEP;
      TPM_NORMAL:
        if (s_otp_act)
          state_next = TPM_OVERTEMP;
        else if (cmd_valid && cmd_code_reg == MODE_STANDBY)
          state_next = TPM_STANDBY;
        else if (cmd_valid && cmd_code_reg == MODE_SLEEP)
          state_next = (!pending_reg && any_src_en) ? TPM_SLEEP : TPM_STANDBY;
      TPM_SLEEP:
        // command wake needs io supply; Normal
        if (cmd_valid && s_io_ok && cmd_code_reg == MODE_NORMAL)
          state_next = TPM_NORMAL;
        else if (cmd_valid && s_io_ok && cmd_code_reg == MODE_STANDBY)
          state_next = TPM_STANDBY;
        // wake to Standby, spi fault excluded
        else if (s_wake || irq_event_i)
          state_next = TPM_STANDBY;
      TPM_OVERTEMP:
        if (s_otp_rel)
          state_next = TPM_STANDBY;
    endcase
    if (uv_sleep)
      state_next = TPM_SLEEP;
    if (s_poff)
      state_next = TPM_OFF;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      state_reg <= TPM_OFF;
    else
      state_reg <= state_next;
  end

  // ****************************************
  // status flags
  // ****************************************
  // sleep cause
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      sleep_cause_flag_o <= 1'b0;
    else if (uv_sleep)
      sleep_cause_flag_o <= 1'b1;
    else if (state_next == TPM_SLEEP && state_reg != TPM_SLEEP)
      sleep_cause_flag_o <= 1'b0;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
      normal_mode_pending_flag_o <= 1'b1;
    else if (state_reg == TPM_NORMAL)
      normal_mode_pending_flag_o <= 1'b0;
  end

  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      overtemp_warning_status_o <= 1'b0;
      overtemp_warning_event_o  <= 1'b0;
    end
    else
    begin
      overtemp_warning_status_o <= s_otw;
      if (s_otw && !overtemp_warning_status_o && overtemp_warning_irq_enable_i)
        overtemp_warning_event_o <= 1'b1;
      else if (wake_clear_i)
        overtemp_warning_event_o <= 1'b0;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // inhibit drive; bus and receive pin
  always_ff @(posedge clock_i)
  begin
    if (rst_i)
    begin
      regulator_inhibit_output_o    <= 1'b0;
      regulator_inhibit_output_oe_o <= 1'b0;
      bus_out_en_o                  <= 1'b0;
      trx_active_o                  <= 1'b0;
      bus_monitor_o                 <= 1'b0;
      selective_wake_mode_o         <= 1'b0;
      rxd_low_o                     <= 1'b0;
    end
    else
    begin
      regulator_inhibit_output_o    <= (state_next == TPM_STANDBY || state_next == TPM_NORMAL
                                        || state_next == TPM_OVERTEMP);
      regulator_inhibit_output_oe_o <= (state_next == TPM_STANDBY || state_next == TPM_NORMAL
                                        || state_next == TPM_OVERTEMP);
      bus_out_en_o                  <= (state_next == TPM_STANDBY || state_next == TPM_NORMAL
                                        || state_next == TPM_SLEEP);
      trx_active_o                  <= (state_next == TPM_NORMAL);
      bus_monitor_o                 <= (state_next == TPM_STANDBY || state_next == TPM_SLEEP)
                                       && bus_wake_enable_o;
      selective_wake_mode_o         <= selective_wake_enable_o && selective_wake_config_valid_i;
      // forced sleep clears pending in this same cycle, so the pin must follow at once
      rxd_low_o                     <= pending_reg && !uv_sleep && state_next != TPM_OFF
                                       && state_next != TPM_STARTUP;
    end
  end

  assign state_o = state_reg;

  // ****************************************
  // assertions
  // ****************************************
  a_poff_to_off: assert property (@(posedge clock_i) disable iff (rst_i)
    s_poff |=> state_reg == TPM_OFF) else $error("battery loss did not enter Off");
  a_otp_entry: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_reg == TPM_NORMAL && s_otp_act && !s_poff && !uv_force) |=> state_reg == TPM_OVERTEMP)
    else $error("overtemp entry missed");
  a_sleep_inh_off: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_reg == TPM_SLEEP && $past(state_reg) == TPM_SLEEP) |-> !regulator_inhibit_output_oe_o)
    else $error("inhibit driven in Sleep");
  a_standby_inh_on: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_reg == TPM_STANDBY && $past(state_reg) == TPM_STANDBY) |-> regulator_inhibit_output_o)
    else $error("inhibit inactive in Standby");
  a_uv_enables: assert property (@(posedge clock_i) disable iff (rst_i)
    uv_sleep |=> bus_wake_enable_o && !selective_wake_enable_o && !pending_reg
      && sleep_cause_flag_o) else $error("undervoltage sleep side effects wrong");
  a_sleep_guard: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_reg != TPM_SLEEP && pending_reg && !uv_sleep) |=> state_reg != TPM_SLEEP)
    else $error("sleep entered with wake pending");
  a_nms_clear: assert property (@(posedge clock_i) disable iff (rst_i)
    state_reg == TPM_NORMAL |=> !normal_mode_pending_flag_o) else $error("normal flag stuck");
  a_rxd_pending: assert property (@(posedge clock_i) disable iff (rst_i)
    (pending_reg && !uv_sleep && !s_poff && state_reg == TPM_STANDBY
      && $past(state_reg) == TPM_STANDBY) |=> rxd_low_o)
    else $error("receive pin not low with wake pending");
  a_spi_fault_event_no_wake: assert property (@(posedge clock_i) disable iff (rst_i)
    (state_reg == TPM_SLEEP && !s_wake && !irq_event_i && !cmd_valid && !s_poff)
      |=> state_reg == TPM_SLEEP) else $error("left Sleep without cause");
  c_boot: cover property (@(posedge clock_i) disable iff (rst_i)
    state_reg == TPM_STARTUP ##1 state_reg == TPM_STANDBY);
  c_uv_sleep: cover property (@(posedge clock_i) disable iff (rst_i) uv_sleep);
  c_overtemp: cover property (@(posedge clock_i) disable iff (rst_i)
    state_reg == TPM_OVERTEMP ##1 state_reg == TPM_STANDBY);
  c_normal: cover property (@(posedge clock_i) disable iff (rst_i)
    state_reg == TPM_SLEEP ##1 state_reg == TPM_NORMAL);

endmodule // tpm_mode_fsm

// [sim/tpm_host_model.sv]
// Purpose: controller model that writes mode codes in the link domain
// Assumes: link clock runs free, one-cycle write pulses
// Notes:   the code lines are scrambled once a write is over
`timescale 1ns/10ps
module tpm_host_model (
  input  wire logic       link_clk_i,
  input  wire logic       rst_req_i,
  output logic            link_rst_o,
  output logic            mode_wr_o,
  output logic [2:0]      mode_select_field_o
);
  initial
  begin
    mode_wr_o           = 1'b0;
    mode_select_field_o = 3'h0;
  end

  always @(posedge link_clk_i)
  begin
    link_rst_o <= rst_req_i;
  end

  task automatic send(input logic [2:0] code);
    @(posedge link_clk_i);
    mode_wr_o           <= 1'b1;
    mode_select_field_o <= code;
    @(posedge link_clk_i);
    mode_wr_o           <= 1'b0;
    mode_select_field_o <= ~code;
    repeat (2) @(posedge link_clk_i);
  endtask
endmodule // tpm_host_model

// [sim/test_tpm_mode_fsm.sv]
// Purpose: self-checking bench of the power-mode state machine
// Assumes: shortened startup and undervoltage counts
// Notes:   one task per scenario
`timescale 1ns/10ps
module test_tpm_mode_fsm;
  import tpm_pkg::*;
  localparam int SU = 8, UV = 4;
  localparam int P_BWS = 0, P_BWC = 1, P_LWS = 2, P_LWC = 3, P_SWS = 4, P_SWC = 5;
  localparam int P_WCLR = 6, P_SPI_FAULT_EVENT = 7, P_IRQ = 8;
  logic clk, rst, lclk, lrst, mwr, bat_pon, bat_poff, vcc_uv, io_ok;
  logic otp_act, otp_rel, overtemp_warning_event, otw_ie, wake_ev, sw_cfg_ok;
  logic [2:0] mfield;
  logic [8:0] pl;
  tpm_state_e state;
  logic regulator_inhibit_output, inh_oe, bus_en, trx, bmon, selm, rxdl, bwe, lwf, lwr, swe, scause, ows, owe, nmp;
  int miscompares = 0;
  int check_count = 0;
  int n;

  tpm_host_model i_tpm_host_model (.link_clk_i(lclk), .rst_req_i(rst), .link_rst_o(lrst),
    .mode_wr_o(mwr), .mode_select_field_o(mfield));
  tpm_mode_fsm #(.STARTUP_CNT(SU), .UV_CNT(UV)) i_tpm_mode_fsm (
    .clock_i(clk), .rst_i(rst), .link_clk_i(lclk), .link_rst_i(lrst), .mode_wr_i(mwr),
    .mode_select_field_i(mfield), .bat_pon_i(bat_pon), .bat_poff_i(bat_poff),
    .vcc_uv_i(vcc_uv), .io_supply_uv_i(1'b0), .io_supply_ok_i(io_ok), .otp_act_i(otp_act),
    .otp_rel_i(otp_rel), .otw_i(overtemp_warning_event), .overtemp_warning_irq_enable_i(otw_ie),
    .wake_event_i(wake_ev), .irq_event_i(pl[P_IRQ]), .spi_fault_event_i(pl[P_SPI_FAULT_EVENT]),
    .bus_wake_enable_set_i(pl[P_BWS]), .bus_wake_enable_clr_i(pl[P_BWC]),
    .local_wake_en_set_i(pl[P_LWS]), .local_wake_en_clr_i(pl[P_LWC]),
    .selective_wake_enable_set_i(pl[P_SWS]), .selective_wake_enable_clr_i(pl[P_SWC]),
    .selective_wake_config_valid_i(sw_cfg_ok), .wake_clear_i(pl[P_WCLR]), .state_o(state),
    .regulator_inhibit_output_o(regulator_inhibit_output), .regulator_inhibit_output_oe_o(inh_oe),
    .bus_out_en_o(bus_en), .trx_active_o(trx), .bus_monitor_o(bmon),
    .selective_wake_mode_o(selm), .rxd_low_o(rxdl), .bus_wake_enable_o(bwe),
    .local_wake_falling_enable_o(lwf), .local_wake_rising_enable_o(lwr),
    .selective_wake_enable_o(swe), .sleep_cause_flag_o(scause),
    .overtemp_warning_status_o(ows), .overtemp_warning_event_o(owe),
    .normal_mode_pending_flag_o(nmp));

  // ****************************************************************
  // clocks and helpers
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  initial
  begin
    lclk = 1'b0;
    #7;
    forever #62.5 lclk = ~lclk;
  end

  task automatic chk(input logic [2:0] seen, input logic [2:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chkb(input logic seen, input logic exp);
    chk({2'h0, seen}, {2'h0, exp});
  endtask

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask

  task automatic pulse(input int b);
    @(posedge clk);
    pl[b] <= 1'b1;
    @(posedge clk);
    pl[b] <= 1'b0;
  endtask

  task automatic wait_st(input tpm_state_e s, output int cnt);
    cnt = 0;
    while (state !== s && cnt < 64)
    begin
      @(posedge clk);
      #1;
      cnt++;
    end
    chk(state, s);
  endtask

  task automatic go(input logic [2:0] code, input tpm_state_e s);
    i_tpm_host_model.send(code);
    wait_st(s, n);
  endtask

  task automatic hold_wake();
    @(posedge clk);
    wake_ev <= 1'b1;
    cyc(4);
    wake_ev <= 1'b0;
  endtask

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic t_reset_powerup();
    cyc(2);
    chk(state, TPM_OFF);
    chkb(inh_oe, 1'b0);
    chkb(bus_en, 1'b0);
    chkb(nmp, 1'b1);
    @(posedge clk);
    bat_pon <= 1'b1;
    wait_st(TPM_STANDBY, n);
    chkb(n >= SU, 1'b1);
    chkb(inh_oe & regulator_inhibit_output, 1'b1);
    chkb(trx, 1'b0);
    chkb(bus_en & bmon, 1'b1);
    pulse(P_BWC);
    cyc(3);
    chkb(bmon, 1'b0);
    pulse(P_BWS);
    pulse(P_SWS);
    cyc(3);
    chkb(selm, 1'b0);
    sw_cfg_ok <= 1'b1;
    cyc(4);
    chkb(selm, 1'b1);
    pulse(P_SWC);
    cyc(3);
    chkb(selm, 1'b0);
  endtask

  task automatic t_sleep_wake();
    go(MODE_NORMAL, TPM_NORMAL);
    chkb(trx, 1'b1);
    cyc(2);
    chkb(nmp, 1'b0);
    go(MODE_SLEEP, TPM_SLEEP);
    chkb(inh_oe, 1'b0);
    chkb(scause, 1'b0);
    pulse(P_SPI_FAULT_EVENT);
    cyc(8);
    chk(state, TPM_SLEEP);
    pulse(P_WCLR);
    hold_wake();
    wait_st(TPM_STANDBY, n);
    chkb(rxdl, 1'b1);
    cyc(3);
    pulse(P_WCLR);
    cyc(3);
    chkb(rxdl, 1'b0);
  endtask

  task automatic t_refused();
    hold_wake();
    i_tpm_host_model.send(MODE_SLEEP);
    cyc(10);
    chk(state, TPM_STANDBY);
    pulse(P_WCLR);
    pulse(P_BWC);
    pulse(P_LWC);
    i_tpm_host_model.send(MODE_SLEEP);
    cyc(10);
    chk(state, TPM_STANDBY);
    pulse(P_BWS);
    pulse(P_LWS);
    go(MODE_SLEEP, TPM_SLEEP);
    io_ok <= 1'b0;
    i_tpm_host_model.send(MODE_NORMAL);
    cyc(10);
    chk(state, TPM_SLEEP);
    io_ok <= 1'b1;
    cyc(3);
    go(MODE_STANDBY, TPM_STANDBY);
  endtask

  task automatic t_undervoltage();
    go(MODE_NORMAL, TPM_NORMAL);
    pulse(P_BWC);
    pulse(P_SWS);
    hold_wake();
    @(posedge clk);
    vcc_uv <= 1'b1;
    wait_st(TPM_SLEEP, n);
    chkb(n >= UV, 1'b1);
    chkb(scause, 1'b1);
    chkb(bwe & lwf & lwr, 1'b1);
    chkb(swe | rxdl, 1'b0);
    vcc_uv <= 1'b0;
    cyc(4);
    pulse(P_IRQ);
    wait_st(TPM_STANDBY, n);
    pulse(P_WCLR);
  endtask

  task automatic t_warning();
    overtemp_warning_event <= 1'b1;
    cyc(4);
    chkb(ows, 1'b1);
    chkb(owe, 1'b0);
    overtemp_warning_event <= 1'b0;
    cyc(4);
    chkb(ows, 1'b0);
    otw_ie <= 1'b1;
    overtemp_warning_event <= 1'b1;
    cyc(4);
    chkb(owe, 1'b1);
    overtemp_warning_event <= 1'b0;
    pulse(P_WCLR);
    cyc(2);
    chkb(owe, 1'b0);
  endtask

  task automatic t_overtemp_off();
    go(MODE_NORMAL, TPM_NORMAL);
    otp_act <= 1'b1;
    wait_st(TPM_OVERTEMP, n);
    chkb(n <= 5, 1'b1);
    chkb(bus_en | trx, 1'b0);
    otp_act <= 1'b0;
    hold_wake();
    cyc(6);
    chk(state, TPM_OVERTEMP);
    chkb(rxdl, 1'b0);
    otp_rel <= 1'b1;
    wait_st(TPM_STANDBY, n);
    otp_rel <= 1'b0;
    go(MODE_NORMAL, TPM_NORMAL);
    otp_act <= 1'b1;
    wait_st(TPM_OVERTEMP, n);
    bat_poff <= 1'b1;
    wait_st(TPM_OFF, n);
    chkb(inh_oe | bus_en, 1'b0);
  endtask

  // ****************************************************************
  // main sequence and watchdog
  // ****************************************************************
  initial
  begin
    rst = 1'b1;
    {bat_pon, bat_poff, vcc_uv, otp_act, otp_rel, overtemp_warning_event, otw_ie, wake_ev, sw_cfg_ok} = '0;
    io_ok = 1'b1;
    pl = '0;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset_powerup();
    t_sleep_wake();
    t_refused();
    t_undervoltage();
    t_warning();
    t_overtemp_off();
    test_done();
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    miscompares++;
    test_done();
  end
endmodule // test_tpm_mode_fsm
